//--- logic/mip_pkg.sv
// Shared types and constants for the multiphase interleaved pulse sequencer
package mip_pkg;

  localparam int unsigned CNT_W          = 16;
  localparam int unsigned NCH            = 4;
  localparam int unsigned CLK_KHZ        = 200000;
  localparam int unsigned SW_FREQ_KHZ    = 250;
  localparam int unsigned MAX_DUTY_PM    = 933;
  localparam int unsigned PM_SCALE       = 1000;

  typedef enum logic [1:0] {
    MIP_ST_OFF = 2'b01,
    MIP_ST_RUN = 2'b10
  } mip_mode_t;

  typedef enum logic [2:0] {
    MIP_CH2 = 3'b001,
    MIP_CH3 = 3'b010,
    MIP_CH4 = 3'b100
  } mip_nch_t;

  typedef struct packed {
    logic           enable;
    logic           chan3_sense_neg;
    logic           chan4_sense_neg;
    logic           transient_detect_pin;
    logic [NCH-1:0] above_ramp;
  } mip_pins_t;

  typedef struct packed {
    logic [NCH-1:0] pulse;
    mip_nch_t       nch;
  } mip_outs_t;

  typedef struct packed {
    mip_mode_t                 mode;
    mip_nch_t                  nch;
    logic [CNT_W-1:0]          cnt;
    mip_pins_t                 meta;
    mip_pins_t                 sync;
    logic [NCH-1:0]            out;
    logic [NCH-1:0]            fired;
    logic [NCH-1:0][CNT_W-1:0] hcnt;
  } mip_state_t;

  localparam mip_pins_t  MIP_PINS_RST  = '0;
  localparam mip_state_t MIP_STATE_RST = '{
    mode:  MIP_ST_OFF,
    nch:   MIP_CH4,
    cnt:   '0,
    meta:  MIP_PINS_RST,
    sync:  MIP_PINS_RST,
    out:   '0,
    fired: '0,
    hcnt:  '0
  };

endpackage

//--- logic/mip_sequencer.sv
// Multiphase interleaved pulse sequencer: timing, pulse logic and channel detection
`timescale 1ns/1ps
`default_nettype none

module mip_sequencer
  import mip_pkg::*;
#(
  parameter int unsigned SW_KHZ = mip_pkg::SW_FREQ_KHZ
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire mip_pkg::mip_pins_t pins,
  output var  logic              chan1_pulse_out,
  output var  logic              chan2_pulse_out,
  output var  logic              chan3_pulse_out,
  output var  logic              chan4_pulse_out,
  output var  mip_pkg::mip_nch_t active_chans
);
  import mip_pkg::*;

  // Interval length from the frequency set externally
  localparam int unsigned PER  = CLK_KHZ / SW_KHZ;
  localparam int unsigned HMAX = (PER * MAX_DUTY_PM) / PM_SCALE;

  localparam logic [CNT_W-1:0] PER_LAST = CNT_W'(PER - 1);
  localparam logic [CNT_W-1:0] HMAX_M1  = CNT_W'(HMAX - 1);
  localparam logic [CNT_W-1:0] OFF_Q1   = CNT_W'(PER / 4);
  localparam logic [CNT_W-1:0] OFF_Q2   = CNT_W'(PER / 2);
  localparam logic [CNT_W-1:0] OFF_Q3   = CNT_W'((3 * PER) / 4);
  localparam logic [CNT_W-1:0] OFF_T1   = CNT_W'(PER / 3);
  localparam logic [CNT_W-1:0] OFF_T2   = CNT_W'((2 * PER) / 3);

  // Refuse periods the counter cannot hold or too short to interleave
  if (PER < 8 || PER >= (1 << CNT_W) || HMAX < 1) begin : g_bad_period
    $error("mip_sequencer: switching period out of range");
  end

  // Ports and loops assume four channels; the ceiling must cut inside the period
  if (NCH != 4 || MAX_DUTY_PM >= PM_SCALE || HMAX >= PER) begin : g_bad_config
    $error("mip_sequencer: channel count or duty ceiling out of range");
  end

  logic       rst_meta_r;
  logic       rst_sync_r;
  mip_state_t st_r;
  mip_state_t st_nxt;

  // Interval start offset of channel i for the detected count
  function automatic logic [CNT_W-1:0] chan_offset(input int unsigned i, input mip_nch_t n);
    logic [CNT_W-1:0] o;
    o = '0;
    case (n)
      MIP_CH4: begin
        case (i)
          0:       o = OFF_Q3;
          1:       o = OFF_Q2;
          2:       o = OFF_Q1;
          default: o = '0;
        endcase
      end
      MIP_CH3: begin
        case (i)
          1:       o = OFF_T1;
          2:       o = OFF_T2;
          default: o = '0;
        endcase
      end
      MIP_CH2: begin
        o = (i == 1) ? OFF_Q2 : '0;
      end
      default: o = '0;
    endcase
    return o;
  endfunction

  function automatic logic chan_active(input int unsigned i, input mip_nch_t n);
    logic a;
    case (n)
      MIP_CH2: a = (i < 2);
      MIP_CH3: a = (i < 3);
      MIP_CH4: a = 1'b1;
      default: a = 1'b0;
    endcase
    return a;
  endfunction

  // Supply-tied sense inputs mark missing channels; channel 3 wins
  function automatic mip_nch_t detect_count(input mip_pins_t p);
    mip_nch_t n;
    if (p.chan3_sense_neg) begin
      n = MIP_CH2;
    end else if (p.chan4_sense_neg) begin
      n = MIP_CH3;
    end else begin
      n = MIP_CH4;
    end
    return n;
  endfunction

  // Reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  always_comb begin
    logic f;
    logic start;
    logic trip;
    logic cmp;
    f      = 1'b0;
    start  = 1'b0;
    trip   = 1'b0;
    cmp    = 1'b0;
    st_nxt = st_r;
    // Pins are asynchronous comparator levels; only the second stage is read
    st_nxt.meta = pins;
    st_nxt.sync = st_r.meta;
    case (st_r.mode)
      MIP_ST_OFF: begin
        // Count tracked continuously while off, frozen once running
        st_nxt.out   = '0;
        st_nxt.fired = '0;
        st_nxt.hcnt  = '0;
        st_nxt.cnt   = '0;
        st_nxt.nch   = detect_count(st_r.sync);
        if (st_r.sync.enable) begin
          st_nxt.mode = MIP_ST_RUN;
        end
      end
      MIP_ST_RUN: begin
        if (!st_r.sync.enable) begin
          st_nxt.mode = MIP_ST_OFF;
          st_nxt.out  = '0;
        end else begin
          // One master count; each channel's interval starts at its offset
          st_nxt.cnt = (st_r.cnt == PER_LAST) ? '0 : st_r.cnt + 1'b1;
          // Trip level is formed by the external resistor before the comparator
          trip = st_r.sync.transient_detect_pin;
          for (int unsigned i = 0; i < NCH; i++) begin
            cmp   = st_r.sync.above_ramp[i];
            start = (st_r.cnt == chan_offset(i, st_r.nch));
            f     = start ? 1'b0 : st_r.fired[i];
            st_nxt.hcnt[i] = st_r.out[i] ? st_r.hcnt[i] + 1'b1 : '0;
            if (!chan_active(i, st_r.nch)) begin
              st_nxt.out[i]  = 1'b0;
              f              = 1'b0;
              st_nxt.hcnt[i] = '0;
            end else if (st_r.out[i] && st_r.hcnt[i] >= HMAX_M1) begin
              // Duty ceiling beats everything, including a transient trip
              st_nxt.out[i] = 1'b0;
              // Cut pulse spends its interval, else a start seen while high re-fires it
              f             = 1'b1;
            end else if (trip && (!f || st_r.out[i])) begin
              // Forced only while the trip holds; no retrigger after a pulse
              st_nxt.out[i] = 1'b1;
              f             = 1'b1;
            end else if (st_r.out[i]) begin
              // Second crossing ends the pulse; the master count, not this end, marks the period
              st_nxt.out[i] = cmp;
            end else if (cmp && !f) begin
              // Rise may happen at any cycle of the interval
              st_nxt.out[i] = 1'b1;
              f             = 1'b1;
            end else begin
              st_nxt.out[i] = 1'b0;
            end
            st_nxt.fired[i] = f;
          end
        end
      end
      default: begin
        st_nxt = MIP_STATE_RST;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      st_r <= MIP_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Low output tells the driver to turn the upper switch off
  assign chan1_pulse_out = st_r.out[0];
  assign chan2_pulse_out = st_r.out[1];
  assign chan3_pulse_out = st_r.out[2];
  assign chan4_pulse_out = st_r.out[3];
  assign active_chans    = st_r.nch;

endmodule // mip_sequencer

`default_nettype wire

//--- tb/mip_gate_model.sv
// Behavioural gate driver pairs of the four channels
`timescale 1ns/1ps
`default_nettype none
module mip_gate_model (
  input  wire logic [3:0] pulse,
  output var  logic [3:0] upper_on,
  output var  logic [3:0] lower_on
);
  assign upper_on = pulse;
  assign lower_on = ~pulse;
endmodule // mip_gate_model
`default_nettype wire

//--- tb/mip_properties.sv
// Port checker for the pulse sequencer
`timescale 1ns/1ps
`default_nettype none
module mip_props
  import mip_pkg::*;
#(
  parameter int unsigned SW_KHZ = mip_pkg::SW_FREQ_KHZ
) (
  input wire logic               clk,
  input wire logic               rstn,
  input wire mip_pkg::mip_pins_t pins,
  input wire logic               chan1_pulse_out,
  input wire logic               chan2_pulse_out,
  input wire logic               chan3_pulse_out,
  input wire logic               chan4_pulse_out,
  input wire mip_pkg::mip_nch_t  active_chans
);
  import mip_pkg::*;
  localparam int unsigned HMAX = CLK_KHZ / SW_KHZ * MAX_DUTY_PM / PM_SCALE;
  logic [CNT_W-1:0] hi_r;
  wire logic        cause = pins.above_ramp[0] | pins.transient_detect_pin;
  wire logic        any_on = chan1_pulse_out | chan2_pulse_out | chan3_pulse_out | chan4_pulse_out;
  mip_nch_t         exp_nch;
  assign exp_nch = pins.chan3_sense_neg ? MIP_CH2 : pins.chan4_sense_neg ? MIP_CH3 : MIP_CH4;
  // Run length of channel 1 only, to keep the checker small
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) hi_r <= '0;
    else hi_r <= chan1_pulse_out ? hi_r + 1'b1 : '0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_reset_idle: assert property ($rose(rstn) |-> !any_on && active_chans == MIP_CH4)
    else $error("reset state");
  a_duty_cap: assert property (hi_r <= HMAX)
    else $error("high too long");
  a_rise_cause: assert property ($rose(chan1_pulse_out) |-> $past(cause, 3))
    else $error("rise without cause");
  a_ramp_low: assert property ((!cause)[*4] |=> !chan1_pulse_out)
    else $error("output not released");
  a_off_low: assert property ((!pins.enable)[*4] |=> !any_on)
    else $error("disabled output high");
  a_idle_chan: assert property (!(chan4_pulse_out && active_chans != MIP_CH4) &&
    !(chan3_pulse_out && active_chans == MIP_CH2))
    else $error("idle channel high");
  a_count_hold: assert property (pins.enable[*8] |=> $stable(active_chans))
    else $error("count moved while running");
  a_count_dec: assert property ((!pins.enable && $stable(pins))[*5] |=>
    active_chans == $past(exp_nch))
    else $error("count decode");
endmodule // mip_props
bind mip_sequencer mip_props #(.SW_KHZ(SW_KHZ)) u_props (.clk(clk), .rstn(rstn), .pins(pins),
  .chan1_pulse_out(chan1_pulse_out), .chan2_pulse_out(chan2_pulse_out),
  .chan3_pulse_out(chan3_pulse_out), .chan4_pulse_out(chan4_pulse_out),
  .active_chans(active_chans));
`default_nettype wire

//--- tb/mip_sequencer_tb.sv
// Self-checking bench for the pulse sequencer
`timescale 1ns/1ps
`default_nettype none
module mip_sequencer_tb;
  import mip_pkg::*;
  // Short period keeps the run brief
  localparam int unsigned SW  = 25000;
  localparam int unsigned PER = CLK_KHZ / SW;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  mip_pins_t  pins = '0;
  wire logic [3:0] po;
  logic [3:0] up;
  logic [3:0] lo;
  logic [3:0] pq = '0;
  mip_nch_t   nch;
  int         n_fail = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         fp = 0;
  int         ft = 0;
  int         rt [4];
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] %0t %s", $time, m); end end
  always #2.5 clk = ~clk;
  mip_sequencer #(.SW_KHZ(SW)) DUT (.clk(clk), .rstn(rstn), .pins(pins),
    .chan1_pulse_out(po[0]), .chan2_pulse_out(po[1]), .chan3_pulse_out(po[2]),
    .chan4_pulse_out(po[3]), .active_chans(nch));
  mip_gate_model u_gate (.pulse(po), .upper_on(up), .lower_on(lo));
  // Rise times of each channel; fall times of channel 1 only
  always @(posedge clk) begin
    cyc++;
    for (int i = 0; i < 4; i++)
      if (po[i] && !pq[i]) rt[i] = cyc;
    if (!po[0] && pq[0]) begin
      fp = ft;
      ft = cyc;
    end
    pq = po;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic setup(input logic s3, input logic s4, input mip_nch_t e);
    pins = '0;
    step(6);
    pins.chan3_sense_neg = s3;
    pins.chan4_sense_neg = s4;
    step(8);
    `CHK(nch, e, "channel count")
    pins.enable = 1'b1;
    step(6);
  endtask
  task automatic t_phase(input logic s3, input logic s4, input mip_nch_t e, input int d [3]);
    setup(s3, s4, e);
    rt = '{-1, -1, -1, -1};
    pins.above_ramp = '1;
    // First periods start in step; measure once the intervals have spread them
    step(4 * PER);
    for (int i = 1; i < 4; i++)
      if (d[i-1] < 0) `CHK(rt[i], -1, "idle channel rose")
      else `CHK((rt[i] - rt[0] + PER) % PER, d[i-1], "offset")
    `CHK(ft - fp, PER, "period")
    `CHK(lo, ~po, "gate pair")
    `CHK(up, po, "upper gate")
    pins.enable = 1'b0;
    step(5);
    `CHK(po, 4'h0, "disabled output")
  endtask
  task automatic t_trip();
    setup(1'b1, 1'b0, MIP_CH2);
    pins.transient_detect_pin = 1'b1;
    step(4);
    `CHK(po, 4'h3, "trip force")
    pins.transient_detect_pin = 1'b0;
    step(4);
    `CHK(po, 4'h0, "trip release")
  endtask
  task automatic t_double();
    setup(1'b0, 1'b0, MIP_CH4);
    // Channel 2 starts its interval at half period, clear of this dip
    pins.above_ramp[1] = 1'b1;
    for (int k = 0; k < 2 * PER && !po[1]; k++) step(1);
    `CHK(po[1], 1'b1, "no rise")
    pins.above_ramp[1] = 1'b0;
    step(1);
    pins.above_ramp[1] = 1'b1;
    step(4);
    `CHK(po[1], 1'b0, "double pulse")
  endtask
  initial begin
    #20us;
    n_fail++;
    wrap_up();
  end
  initial begin
    step(16);
    rstn = 1'b1;
    step(2);
    `CHK(po, 4'h0, "reset outputs")
    t_phase(1'b0, 1'b0, MIP_CH4, '{PER - PER / 4, PER / 2, PER / 4});
    t_phase(1'b0, 1'b1, MIP_CH3, '{PER / 3, 2 * PER / 3, -1});
    t_phase(1'b1, 1'b0, MIP_CH2, '{PER / 2, -1, -1});
    t_trip();
    t_double();
    wrap_up();
  end
endmodule // mip_sequencer_tb
`undef CHK
`default_nettype wire
